// >>> dv/bdm_host.sv
// background debug host model issuing byte writes over the link
`timescale 1ns/1ps
module bdm_host
  import reset_cause_pkg::*;
(
  input wire logic sys_clk,
  output logic bdm_wr,
  output logic [ADDR_W-1:0] bdm_addr,
  output logic [7:0] bdm_wdata
);
  initial
  begin
    bdm_wr = 1'b0;
    bdm_addr = 16'h0000;
    bdm_wdata = 8'h00;
  end

  // byte write command after an idle gap; lines show a changed value once released
  task write_byte(input logic [15:0] addr, input logic [7:0] data, input int gap);
    repeat (gap) @(negedge sys_clk);
    bdm_wr = 1'b1;
    bdm_addr = addr;
    bdm_wdata = data;
    @(negedge sys_clk);
    bdm_wr = 1'b0;
    bdm_addr = ~addr;
    bdm_wdata = ~data;
  endtask : write_byte
endmodule : bdm_host

// >>> dv/reset_cause_capture_tb.sv
// self-checking bench for the reset-cause capture block
`timescale 1ns/1ps
module reset_cause_capture_tb
  import reset_cause_pkg::*;
;
  localparam int WDOG = 20;
  logic sys_clk = 1'b0;
  logic resetn, reset_pin_n, watchdog_enable, background_mode_enable, low_voltage_reset;
  logic low_voltage_detect, low_voltage_reset_enable, low_voltage_stop_enable, clockgen_reset;
  logic illegal_opcode, stop_exec, background_entry_instruction_exec, stop_mode_enable_wr, stop_mode_enable_in;
  logic cpu_rd, cpu_wr, rd_pend, bdm_wr, system_reset;
  logic [ADDR_W-1:0] cpu_addr, bdm_addr, gap_addr;
  logic [7:0] cpu_rdata, bdm_wdata;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int num_checks = 0;

  always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

  reset_cause_capture #(.WDOG_CYCLES(WDOG)) u_reset_cause_capture (
    .sys_clk(sys_clk), .resetn(resetn), .reset_pin_n(reset_pin_n),
    .watchdog_enable(watchdog_enable), .background_mode_enable(background_mode_enable),
    .low_voltage_reset(low_voltage_reset), .low_voltage_detect(low_voltage_detect),
    .low_voltage_reset_enable(low_voltage_reset_enable),
    .low_voltage_stop_enable(low_voltage_stop_enable), .clockgen_reset(clockgen_reset),
    .illegal_opcode(illegal_opcode), .stop_exec(stop_exec), .background_entry_instruction_exec(background_entry_instruction_exec),
    .stop_mode_enable_wr(stop_mode_enable_wr), .stop_mode_enable_in(stop_mode_enable_in),
    .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_rdata(cpu_rdata),
    .bdm_wr(bdm_wr), .bdm_addr(bdm_addr), .bdm_wdata(bdm_wdata), .system_reset(system_reset)
  );

  bdm_host u_bdm_host (.sys_clk(sys_clk), .bdm_wr(bdm_wr), .bdm_addr(bdm_addr),
    .bdm_wdata(bdm_wdata));

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task finish_test;
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // read data lands one cycle after the strobe; compare against the oldest note
  always @(posedge sys_clk) rd_pend <= cpu_rd;
  always @(negedge sys_clk)
  begin
    if (rd_pend === 1'b1)
      check(cpu_rdata, exp_q.pop_front());
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    finish_test();
  end

  // ----------------------------------------
  // stimulus tasks
  // ----------------------------------------
  task access(input logic [15:0] addr, input logic rd, input logic [7:0] exp);
    @(negedge sys_clk);
    cpu_addr = addr;
    cpu_rd = rd;
    cpu_wr = ~rd;
    if (rd)
      exp_q.push_back(exp);
    @(negedge sys_clk);
    {cpu_rd, cpu_wr} = 2'b00;
    @(negedge sys_clk);
  endtask : access

  // one-cycle cause: pin, opcode, stop, background_entry_instruction, clockgen, lvr, lv detect, gap write
  task pulse(input logic [7:0] src);
    @(negedge sys_clk);
    reset_pin_n = ~src[0];
    {clockgen_reset, background_entry_instruction_exec, stop_exec, illegal_opcode} = src[4:1];
    {cpu_wr, low_voltage_detect, low_voltage_reset} = src[7:5];
    if (src[7])
      cpu_addr = gap_addr;
    @(negedge sys_clk);
    {reset_pin_n, illegal_opcode, stop_exec, background_entry_instruction_exec} = 4'b1000;
    {clockgen_reset, low_voltage_reset, low_voltage_detect, cpu_wr} = 4'b0000;
  endtask : pulse

  task wait_reset(output logic [7:0] cnt);
    int n;
    n = 0;
    cnt = 8'h00;
    while (system_reset !== 1'b1 && n < 64)
    begin
      @(negedge sys_clk);
      n++;
    end
    while (system_reset === 1'b1 && cnt < 8'hff)
    begin
      @(negedge sys_clk);
      cnt++;
    end
    if (n >= 64)
      check(8'h00, 8'h01);
  endtask : wait_reset

  task fire(input logic [7:0] src, input logic [7:0] exp);
    logic [7:0] c;
    pulse(src);
    wait_reset(c);
    access(STATUS_ADDR, 1'b1, exp);
  endtask : fire

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] c;
    {resetn, watchdog_enable, background_mode_enable, low_voltage_reset} = 4'h0;
    {low_voltage_detect, low_voltage_reset_enable, low_voltage_stop_enable} = 3'h0;
    {clockgen_reset, illegal_opcode, stop_exec, background_entry_instruction_exec} = 4'h0;
    {stop_mode_enable_wr, stop_mode_enable_in, cpu_rd, cpu_wr} = 4'h0;
    reset_pin_n = 1'b1;
    cpu_addr = 16'h0000;
    gap_addr = 16'h0000;
    void'($urandom(39723));
    repeat (4) @(negedge sys_clk);
    resetn = 1'b1;
    access(STATUS_ADDR, 1'b1, FLAGS_POR);
    access(FORCE_ADDR, 1'b1, FORCE_RD_VALUE);
    access(FORCE_ADDR, 1'b0, 8'h00);
    access(STATUS_ADDR, 1'b1, FLAGS_POR);
    fire(8'h20, 8'h82);
    fire(8'h01, 8'h40);
    fire(8'h02, 8'h10);
    fire(8'h04, 8'h10);
    fire(8'h08, 8'h10);
    fire(8'h13, 8'h54);
    fire(8'h10, 8'h04);
    gap_addr = 16'($urandom_range(GAP0_HI, GAP0_LO));
    fire(8'h80, 8'h08);
    gap_addr = 16'($urandom_range(GAP1_HI, GAP1_LO));
    fire(8'h80, 8'h08);
    gap_addr = GAP0_HI;
    fire(8'h80, 8'h08);
    access(16'h1850, 1'b0, 8'h00);
    access(16'h046f, 1'b0, 8'h00);
    access(STATUS_ADDR, 1'b1, 8'h08);
    pulse(8'h40);
    access(STATUS_ADDR, 1'b1, 8'h08);
    {low_voltage_reset_enable, low_voltage_stop_enable} = 2'b11;
    fire(8'h40, 8'h02);
    stop_mode_enable_in = 1'b1;
    stop_mode_enable_wr = 1'b1;
    @(negedge sys_clk);
    stop_mode_enable_wr = 1'b0;
    background_mode_enable = 1'b1;
    pulse(8'h0c);
    access(STATUS_ADDR, 1'b1, 8'h02);
    fire(8'h01, 8'h40);
    fire(8'h04, 8'h10);
    u_bdm_host.write_byte(FORCE_ADDR, 8'($urandom) | 8'h01, 3);
    wait_reset(c);
    check(c, 8'(HOLD_CYCLES));
    access(STATUS_ADDR, 1'b1, FLAGS_CLR);
    repeat (2 * WDOG) @(negedge sys_clk);
    access(STATUS_ADDR, 1'b1, FLAGS_CLR);
    watchdog_enable = 1'b1;
    repeat (6)
    begin
      repeat (WDOG / 2) @(negedge sys_clk);
      access(STATUS_ADDR, 1'b0, 8'h00);
    end
    access(STATUS_ADDR, 1'b1, FLAGS_CLR);
    wait_reset(c);
    watchdog_enable = 1'b0;
    access(STATUS_ADDR, 1'b1, 8'h20);
    access(STATUS_ADDR, 1'b1, 8'h20);
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    access(STATUS_ADDR, 1'b1, FLAGS_POR);
    finish_test();
  end
endmodule : reset_cause_capture_tb

// >>> hdl/addr_range_hit.sv
// address window comparator
`timescale 1ns/1ps
module addr_range_hit
  import reset_cause_pkg::*;
#(
  parameter logic [ADDR_W-1:0] LO = 16'h0000,
  parameter logic [ADDR_W-1:0] HI = 16'hffff
) (
  input wire logic [ADDR_W-1:0] addr,
  output logic hit
);

  if (LO > HI)
  begin : g_chk
    $error("addr_range_hit: LO above HI");
  end

  assign hit = (addr >= LO) && (addr <= HI);

endmodule : addr_range_hit

// >>> hdl/reset_cause_capture.sv
// reset-cause capture, force-reset control and reset sequencing
`timescale 1ns/1ps
module reset_cause_capture
  import reset_cause_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = WDOG_CYCLES_DFLT
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic reset_pin_n,
  input wire logic watchdog_enable,
  input wire logic background_mode_enable,
  input wire logic low_voltage_reset,
  input wire logic low_voltage_detect,
  input wire logic low_voltage_reset_enable,
  input wire logic low_voltage_stop_enable,
  input wire logic clockgen_reset,
  input wire logic illegal_opcode,
  input wire logic stop_exec,
  input wire logic background_entry_instruction_exec,
  input wire logic stop_mode_enable_wr,
  input wire logic stop_mode_enable_in,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  output logic [7:0] cpu_rdata,
  input wire logic bdm_wr,
  input wire logic [ADDR_W-1:0] bdm_addr,
  input wire logic [7:0] bdm_wdata,
  output logic system_reset
);

  if (HOLD_CYCLES < 1 || HOLD_CYCLES > (2 ** HOLD_CNT_W))
  begin : g_chk
    $error("reset_cause_capture: hold count does not fit");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    seq_state_t st;
    logic [HOLD_CNT_W-1:0] cnt;
    logic [7:0] flags;
    logic [7:0] rdata;
    logic stop_en;
  } core_t;

  localparam core_t CORE_RST = '{
    st: ST_RUN,
    cnt: '0,
    flags: FLAGS_POR,
    rdata: FORCE_RD_VALUE,
    stop_en: 1'b0
  };

  core_t q;
  core_t d;

  // ----------------------------------------
  // reset sources
  // ----------------------------------------
  logic run;
  logic cpu_access;
  logic gap0_hit;
  logic gap1_hit;
  logic status_wr;
  logic lvr_evt;
  logic dbg_evt;
  logic pin_evt;
  logic wd_evt;
  logic opc_evt;
  logic adr_evt;
  logic clk_evt;
  logic any_cause;
  logic hold_src;
  logic wd_restart;

  assign run = (q.st == ST_RUN);
  assign cpu_access = cpu_rd || cpu_wr;

  addr_range_hit #(
    .LO(GAP0_LO),
    .HI(GAP0_HI)
  ) u_gap0 (
    .addr(cpu_addr),
    .hit(gap0_hit)
  );

  addr_range_hit #(
    .LO(GAP1_LO),
    .HI(GAP1_HI)
  ) u_gap1 (
    .addr(cpu_addr),
    .hit(gap1_hit)
  );

  // register areas lie outside both gaps, so reserved locations never trip
  assign adr_evt = cpu_access && (gap0_hit || gap1_hit);

  // write of any value restarts the watchdog only
  assign status_wr = cpu_wr && (cpu_addr == STATUS_ADDR);
  assign wd_restart = status_wr || !run;

  watchdog_counter #(
    .CYCLES(WDOG_CYCLES)
  ) u_wdog (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .enable(watchdog_enable),
    .restart(wd_restart),
    .timeout(wd_evt)
  );

  // low-voltage trip counts only with both enables set
  assign lvr_evt = low_voltage_reset ||
                   (low_voltage_detect && low_voltage_reset_enable &&
                    low_voltage_stop_enable);
  // only the background link reaches the force bit; cpu writes there do nothing
  assign dbg_evt = bdm_wr && (bdm_addr == FORCE_ADDR) && bdm_wdata[FORCE_BIT];
  assign pin_evt = !reset_pin_n;
  assign opc_evt = illegal_opcode ||
                   (stop_exec && !q.stop_en) ||
                   (background_entry_instruction_exec && !background_mode_enable);
  assign clk_evt = clockgen_reset;
  assign any_cause = lvr_evt || dbg_evt || pin_evt || wd_evt || opc_evt || adr_evt ||
                     clk_evt;
  // reset is stretched while the pin or low voltage persists
  assign hold_src = pin_evt || lvr_evt;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    unique case (q.st)
      ST_RUN:
      begin
        if (any_cause)
        begin
          d.st = ST_HOLD;
          d.cnt = HOLD_CNT_W'(HOLD_CYCLES - 1);
          d.stop_en = 1'b0;
          d.flags = FLAGS_CLR;
          if (lvr_evt)
          begin
            d.flags[POR_BIT] = q.flags[POR_BIT];
            d.flags[LV_BIT] = 1'b1;
          end
          else if (!dbg_evt)
          begin
            // a debug-forced reset without a low-voltage reset leaves all flags clear
            d.flags[PIN_BIT] = pin_evt;
            d.flags[WDOG_BIT] = wd_evt;
            d.flags[OPC_BIT] = opc_evt;
            d.flags[ADR_BIT] = adr_evt;
            d.flags[CLK_BIT] = clk_evt;
          end
        end
        else if (stop_mode_enable_wr)
        begin
          d.stop_en = stop_mode_enable_in;
        end
      end
      ST_HOLD:
      begin
        d.stop_en = 1'b0;
        if (q.cnt != '0)
        begin
          d.cnt = q.cnt - 1'b1;
        end
        else if (!hold_src)
        begin
          d.st = ST_RUN;
        end
      end
    endcase
    if (cpu_rd)
    begin
      if (cpu_addr == STATUS_ADDR)
      begin
        d.rdata = {q.flags[7:1], 1'b0};
      end
      else
      begin
        d.rdata = FORCE_RD_VALUE;
      end
    end
  end

  // power-on loads the power-on and low-voltage flags
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= CORE_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign cpu_rdata = q.rdata;
  assign system_reset = (q.st == ST_HOLD);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  logic seen_q;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seen_q <= 1'b0;
    end
    else
    begin
      seen_q <= 1'b1;
    end
  end

  // causes other than low voltage, for the gating checks
  logic non_lv_cause;

  assign non_lv_cause = dbg_evt || pin_evt || wd_evt || opc_evt || adr_evt || clk_evt;

  // reset entry and the first eight cycles of the stretch that follows it
  sequence s_cause_taken;
    run && any_cause;
  endsequence

  sequence s_debug_taken;
    run && dbg_evt;
  endsequence

  sequence s_reset_stretch;
    system_reset [*8];
  endsequence

  // ----------------------------------------
  // capture checks
  // ----------------------------------------
  a_por_value: assert property (!seen_q |-> q.flags == FLAGS_POR)
    else $error("power-on flags wrong");
  a_flags_frozen: assert property (!(run && any_cause) |=> $stable(q.flags))
    else $error("flags changed outside reset entry");
  a_debug_clear: assert property (run && dbg_evt && !lvr_evt |=> q.flags == FLAGS_CLR)
    else $error("debug reset left a flag set");
  a_restart_keeps: assert property (status_wr && run && !any_cause
    |=> $stable(q.flags) && !system_reset)
    else $error("status write disturbed flags");
  a_lvr_flags: assert property (run && lvr_evt
    |=> q.flags[LV_BIT] && q.flags[6:2] == 5'h0
    && q.flags[POR_BIT] == $past(q.flags[POR_BIT]))
    else $error("low-voltage flags wrong");
  a_pin_flags: assert property (run && pin_evt && !lvr_evt && !dbg_evt
    |=> q.flags[PIN_BIT] && !q.flags[POR_BIT] && !q.flags[LV_BIT])
    else $error("pin reset flags wrong");
  a_wdog_reset: assert property (run && wd_evt && !lvr_evt && !dbg_evt
    |=> system_reset && q.flags[WDOG_BIT])
    else $error("watchdog timeout did not reset");
  a_wdog_gate: assert property (run && !watchdog_enable && !lvr_evt
    && !dbg_evt && !pin_evt && !opc_evt && !adr_evt && !clk_evt |=> !system_reset)
    else $error("watchdog fired while disabled");
  a_opc_flag: assert property (run && illegal_opcode && !lvr_evt && !dbg_evt
    |=> system_reset && q.flags[OPC_BIT])
    else $error("illegal opcode did not reset");
  a_stop_illegal: assert property (run && stop_exec && !q.stop_en && !lvr_evt
    && !dbg_evt |=> system_reset && q.flags[OPC_BIT])
    else $error("stop not treated as illegal");
  a_stop_legal: assert property (run && stop_exec && q.stop_en && !illegal_opcode
    && !(background_entry_instruction_exec && !background_mode_enable) |-> !opc_evt)
    else $error("enabled stop treated as illegal");
  a_background_entry_instruction_illegal: assert property (run && background_entry_instruction_exec && !background_mode_enable
    && !lvr_evt && !dbg_evt |=> q.flags[OPC_BIT])
    else $error("background entry not treated as illegal");
  a_background_entry_instruction_legal: assert property (run && background_entry_instruction_exec && background_mode_enable
    && !illegal_opcode && !(stop_exec && !q.stop_en) |-> !opc_evt)
    else $error("enabled background entry treated as illegal");
  a_gap_reset: assert property (run && cpu_access && !lvr_evt && !dbg_evt
    && cpu_addr inside {[GAP0_LO:GAP0_HI], [GAP1_LO:GAP1_HI]}
    |=> system_reset && q.flags[ADR_BIT])
    else $error("gap access did not reset");
  a_reg_area: assert property (cpu_access
    && !(cpu_addr inside {[GAP0_LO:GAP0_HI], [GAP1_LO:GAP1_HI]}) |-> !adr_evt)
    else $error("legal address raised an address reset");
  a_clk_flag: assert property (run && clk_evt && !lvr_evt && !dbg_evt
    |=> system_reset && q.flags[CLK_BIT])
    else $error("clock-generator reset not captured");
  a_lv_trip: assert property (run && low_voltage_detect && low_voltage_reset_enable
    && low_voltage_stop_enable |=> system_reset && q.flags[LV_BIT])
    else $error("low-voltage trip did not reset");
  a_lv_blocked: assert property (run && low_voltage_detect && !low_voltage_reset_enable
    && !low_voltage_reset && !non_lv_cause |=> !system_reset)
    else $error("low-voltage detect reset without enable");

  // ----------------------------------------
  // hold and release checks
  // ----------------------------------------
  a_first_idle: assert property (!seen_q |-> !system_reset)
    else $error("reset active after power-on release");
  a_hold_stretch: assert property (s_cause_taken |=> s_reset_stretch)
    else $error("reset not held");
  a_debug_stretch: assert property (s_debug_taken |=>
    s_reset_stretch ##1 s_reset_stretch)
    else $error("forced reset too short");
  a_hold_release: assert property (system_reset && q.cnt == '0 && !hold_src
    |=> !system_reset)
    else $error("reset held too long");
  a_pin_hold: assert property (system_reset && !reset_pin_n |=> system_reset)
    else $error("reset released while pin low");
  a_no_cause: assert property (run && !any_cause
    |=> !system_reset)
    else $error("reset without a cause");

  // ----------------------------------------
  // bus checks
  // ----------------------------------------
  a_force_reads: assert property (cpu_rd && cpu_addr == FORCE_ADDR
    |=> cpu_rdata == FORCE_RD_VALUE)
    else $error("force register read not zero");
  a_user_ignored: assert property (run && cpu_wr && cpu_addr == FORCE_ADDR
    && !any_cause |=> !system_reset)
    else $error("user write forced a reset");
  a_status_read: assert property (cpu_rd && cpu_addr == STATUS_ADDR
    |=> cpu_rdata == {$past(q.flags[7:1]), 1'b0})
    else $error("status read wrong");
  a_bit0_zero: assert property (cpu_rdata[0] == 1'b0)
    else $error("read data bit 0 set");
  a_rdata_stands: assert property (!cpu_rd |=> $stable(cpu_rdata))
    else $error("read data changed without a read");
  a_stop_write: assert property (run && !any_cause && stop_mode_enable_wr
    |=> q.stop_en == $past(stop_mode_enable_in))
    else $error("stop enable not loaded");
  a_stop_default: assert property (system_reset |-> !q.stop_en)
    else $error("stop enable survived reset");

endmodule : reset_cause_capture

// >>> hdl/watchdog_counter.sv
// watchdog counter with restart and enable
`timescale 1ns/1ps
module watchdog_counter
  import reset_cause_pkg::*;
#(
  parameter int unsigned CYCLES = WDOG_CYCLES_DFLT
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic restart,
  output logic timeout
);

  localparam int unsigned W = $clog2(CYCLES + 1);

  if (CYCLES < 2)
  begin : g_chk
    $error("watchdog_counter: CYCLES below 2");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
  } wdog_t;

  wdog_t q;
  wdog_t d;

  // no timeout while disabled
  assign timeout = enable && (q.cnt == W'(CYCLES - 1));

  always_comb
  begin
    d = q;
    if (restart || !enable || timeout)
    begin
      d.cnt = '0;
    end
    else
    begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '{cnt: '0};
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_restart_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
    restart |=> q.cnt == '0)
    else $error("watchdog not restarted");

endmodule : watchdog_counter

// >>> include/reset_cause_pkg.sv
// constants and types shared by the reset-cause capture block
// Functional notes
// - seven read-only flags record the source of the most recent reset.
// - a debug-forced reset leaves every reset-cause flag cleared; here a low-voltage reset in the same cycle sets bit 1 and keeps bit 7.
// - any write to the status address restarts the watchdog, flags unchanged.
// - power-on sets power-on bit 7 and low-voltage bit 1, clears others.
// - low-voltage reset keeps power-on bit, sets low-voltage, clears bits 6 to 2.
// - other resets set each active source flag, clear the rest and bits 7, 1.
// - external pin held low sets the pin flag, bit 6.
// - watchdog timeout sets bit 5; source blocked while watchdog enable is 0.
// - illegal or unimplemented opcode resets and sets bit 4.
// - stop instruction is illegal while stop-mode enable is 0.
// - background-entry instruction is illegal while background-mode enable is 0.
// - access to a designated illegal address resets and sets bit 3.
// - two gaps are illegal: 0x0470-0x17FF and 0x1860-0xBFFF.
// - unused or reserved register locations never cause an address reset.
// - clock-generator reset sets bit 2.
// - low-voltage detect with both enables set resets and sets bit 1.
// - force-reset register holds one write-only bit and always reads 0x00.
// - user-program writes to the force-reset register are ignored.
// - writing 1 to bit 0 through the background link forces a full reset.
// - stop-mode enable is 0 after every reset until software sets it.
package reset_cause_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned HOLD_TIME_NS = 640;
  localparam int unsigned HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CNT_W = 5;
  localparam int unsigned WDOG_TIMEOUT_US = 10000;
  localparam int unsigned WDOG_CYCLES_DFLT = WDOG_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

  // ----------------------------------------
  // address map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] STATUS_ADDR = 16'h1800;
  localparam logic [15:0] FORCE_ADDR = 16'h1801;
  localparam logic [15:0] GAP0_LO = 16'h0470;
  localparam logic [15:0] GAP0_HI = 16'h17ff;
  localparam logic [15:0] GAP1_LO = 16'h1860;
  localparam logic [15:0] GAP1_HI = 16'hbfff;

  // ----------------------------------------
  // status fields and values
  // ----------------------------------------
  localparam int unsigned POR_BIT = 7;
  localparam int unsigned PIN_BIT = 6;
  localparam int unsigned WDOG_BIT = 5;
  localparam int unsigned OPC_BIT = 4;
  localparam int unsigned ADR_BIT = 3;
  localparam int unsigned CLK_BIT = 2;
  localparam int unsigned LV_BIT = 1;
  localparam int unsigned FORCE_BIT = 0;
  localparam logic [7:0] FLAGS_POR = 8'h82;
  localparam logic [7:0] FLAGS_CLR = 8'h00;
  localparam logic [7:0] FORCE_RD_VALUE = 8'h00;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } seq_state_t;

endpackage : reset_cause_pkg
